/* design/tw_master.sv */
// two-wire master transfer control with an APB register slave
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
// What this block does
// - after the write address, set the flag again with $18, $20 or $38
// - data writes while the flag is low are dropped and set write collision
// - writing flag one, start and stop zero, enable one sends the loaded byte
// - flag one, stop one, start zero, enable one places a STOP
// - flag one, start one, stop zero, enable one gives a repeated START
// - after repeated START report $10 and keep owning the bus
// - on $08 software loads the write address; device sends it, samples acknowledge
// - on $10 a read address switches to receive, a write address stays transmit
// - in address or data sent states a loaded byte is sent with acknowledge sampled
// - in those states start one, stop zero sends a repeated START
// - in those states stop one sends STOP and hardware clears the stop bit
// - start and stop both one sends STOP then START, stop bit cleared
// - write address acknowledged gives $18, not acknowledged gives $20
// - data acknowledged gives $28, not acknowledged gives $30
// - arbitration loss gives $38; then release the bus or queue a START
// - master work begins with START; address direction picks transmit or receive
// - flag, start and enable set: START when the bus is free, then $08
// - the transfer stays suspended while the flag is set
module tw_master
  import tw_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_RUN = 2'b01,
    C_HOLD = 2'b10
  } tw_cst_t;

  tw_cst_t st_r;
  logic flag_r, ack_en_r, sta_r, sto_r, wc_r, en_r, ie_r;
  logic own_r, addr_ph_r, rx_r, chain_r;
  logic [4:0] code_r;
  logic [1:0] pre_r;
  logic [7:0] data_r;
  logic setup, mapped, acc, wr_ctl, wr_stat, wr_data;
  logic w_sta, w_sto, go_ok;
  logic [7:0] ctl_word, stat_word, rd_byte;

  tw_eng_if eng ();

  tw_eng u_eng (
    .clk(clk),
    .resetn(resetn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .bus(eng)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: one wait-free access phase per transfer
  assign setup = psel && !penable;
  assign mapped = paddr == ADDR_CTRL || paddr == ADDR_STAT || paddr == ADDR_DATA;
  assign acc = psel && penable && pready && pwrite && !pslverr;
  assign wr_ctl = acc && paddr == ADDR_CTRL;
  assign wr_stat = acc && paddr == ADDR_STAT;
  assign wr_data = acc && paddr == ADDR_DATA;

  assign ctl_word = {flag_r, ack_en_r, sta_r, sto_r, wc_r, en_r, 1'b0, ie_r};
  assign stat_word = {code_r, 1'b0, pre_r};

  always_comb begin
    rd_byte = 8'h00;
    if (paddr == ADDR_CTRL) rd_byte = ctl_word;
    else if (paddr == ADDR_STAT) rd_byte = stat_word;
    else if (paddr == ADDR_DATA) rd_byte = data_r;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup) prdata <= {24'h000000, rd_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data register, write collision and prescaler field
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_r <= DATA_RST;
      wc_r <= 1'b0;
      pre_r <= PRE_RST;
    end else begin
      if (wr_data) begin
        if (flag_r) begin
          data_r <= pwdata[7:0];
          wc_r <= 1'b0;
        end else begin
          wc_r <= 1'b1;
        end
      end
      if (wr_stat) pre_r <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer control
  assign w_sta = pwdata[CB_STA];
  assign w_sto = pwdata[CB_STO];
  assign go_ok = pwdata[CB_FLAG] && st_r != C_RUN;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= C_IDLE;
      flag_r <= 1'b0;
      ack_en_r <= 1'b0;
      sta_r <= 1'b0;
      sto_r <= 1'b0;
      en_r <= 1'b0;
      ie_r <= 1'b0;
      own_r <= 1'b0;
      addr_ph_r <= 1'b0;
      rx_r <= 1'b0;
      chain_r <= 1'b0;
      code_r <= ST_IDLE[7:SB_CODE];
      eng.go <= 1'b0;
      eng.abort <= 1'b0;
      eng.cmd <= CMD_NONE;
      eng.tx <= 8'h00;
    end else begin
      eng.go <= 1'b0;
      eng.abort <= 1'b0;
      if (wr_ctl) begin
        ack_en_r <= pwdata[CB_ACK];
        sta_r <= w_sta;
        sto_r <= w_sto;
        en_r <= pwdata[CB_EN];
        ie_r <= pwdata[CB_IE];
        if (pwdata[CB_FLAG]) flag_r <= 1'b0;
        if (!pwdata[CB_EN]) begin
          eng.abort <= 1'b1;
          st_r <= C_IDLE;
          own_r <= 1'b0;
          chain_r <= 1'b0;
          flag_r <= 1'b0;
          code_r <= ST_IDLE[7:SB_CODE];
        end else if (go_ok) begin
          if (w_sto && own_r) begin
            eng.cmd <= CMD_STOP;
            eng.go <= 1'b1;
            chain_r <= w_sta;
            st_r <= C_RUN;
          end else if (w_sta) begin
            // waits in the sequencer until the bus is free
            eng.cmd <= CMD_START;
            eng.go <= 1'b1;
            st_r <= C_RUN;
          end else if (st_r == C_HOLD && own_r) begin
            eng.cmd <= CMD_BYTE;
            eng.tx <= data_r;
            eng.go <= 1'b1;
            st_r <= C_RUN;
          end else begin
            st_r <= C_IDLE;
            code_r <= ST_IDLE[7:SB_CODE];
          end
        end
      end
      if (eng.done) begin
        unique case (eng.cmd)
          CMD_START: begin
            code_r <= own_r ? ST_RSTART[7:SB_CODE] : ST_START[7:SB_CODE];
            own_r <= 1'b1;
            addr_ph_r <= 1'b1;
            flag_r <= 1'b1;
            st_r <= C_HOLD;
          end
          CMD_STOP: begin
            if (!wr_ctl) sto_r <= 1'b0;
            own_r <= 1'b0;
            if (chain_r) begin
              chain_r <= 1'b0;
              eng.cmd <= CMD_START;
              eng.go <= 1'b1;
            end else begin
              code_r <= ST_IDLE[7:SB_CODE];
              st_r <= C_IDLE;
            end
          end
          CMD_BYTE: begin
            flag_r <= 1'b1;
            st_r <= C_HOLD;
            if (eng.lost) begin
              code_r <= ST_ARB[7:SB_CODE];
              own_r <= 1'b0;
            end else if (addr_ph_r) begin
              addr_ph_r <= 1'b0;
              rx_r <= eng.tx[0];
              if (eng.tx[0])
                code_r <= eng.nack ? ST_AR_NACK[7:SB_CODE] : ST_AR_ACK[7:SB_CODE];
              else
                code_r <= eng.nack ? ST_AW_NACK[7:SB_CODE] : ST_AW_ACK[7:SB_CODE];
            end else begin
              code_r <= eng.nack ? ST_D_NACK[7:SB_CODE] : ST_D_ACK[7:SB_CODE];
            end
          end
          CMD_NONE: st_r <= st_r;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain pin drivers; the sequencer keeps the clock low after each START and completed byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= eng.scl_low;
      sda_oe <= eng.sda_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  logic byte_done, start_done, stop_done;
  assign byte_done = eng.done && eng.cmd == CMD_BYTE;
  assign start_done = eng.done && eng.cmd == CMD_START;
  assign stop_done = eng.done && eng.cmd == CMD_STOP;

  a_addr_w_code: assert property (
    byte_done && addr_ph_r && !eng.lost && !eng.tx[0] |=>
      flag_r && {code_r, 3'b000} == ($past(eng.nack) ? ST_AW_NACK : ST_AW_ACK))
    else $error("write address status wrong");

  a_wc_discard: assert property (
    wr_data && !flag_r |=> wc_r && data_r == $past(data_r))
    else $error("late data write not discarded");

  a_byte_launch: assert property (
    wr_ctl && pwdata[CB_FLAG] && pwdata[CB_EN] && !w_sta && !w_sto && st_r == C_HOLD && own_r |=>
      eng.go && eng.cmd == CMD_BYTE && eng.tx == data_r && !flag_r)
    else $error("byte not launched on flag clear");

  a_stop_launch: assert property (
    wr_ctl && pwdata[CB_FLAG] && pwdata[CB_EN] && w_sto && st_r == C_HOLD && own_r |=>
      eng.go && eng.cmd == CMD_STOP)
    else $error("stop not launched");

  a_rstart_launch: assert property (
    wr_ctl && pwdata[CB_FLAG] && pwdata[CB_EN] && w_sta && !w_sto && st_r == C_HOLD |=>
      eng.go && eng.cmd == CMD_START)
    else $error("repeated start not launched");

  a_rstart_code: assert property (
    start_done && own_r |=> flag_r && own_r && {code_r, 3'b000} == ST_RSTART)
    else $error("repeated start status wrong");

  a_start_code: assert property (
    start_done && !own_r |=> flag_r && {code_r, 3'b000} == ST_START)
    else $error("start status wrong");

  a_rx_mode: assert property (
    byte_done && addr_ph_r && !eng.lost |=> rx_r == $past(eng.tx[0]) && !addr_ph_r)
    else $error("mode not taken from direction bit");

  a_stop_clear: assert property (
    stop_done && !wr_ctl |=> !sto_r && !own_r)
    else $error("stop bit not cleared");

  a_stop_start: assert property (
    stop_done && chain_r |=> eng.go && eng.cmd == CMD_START ##1 st_r == C_RUN)
    else $error("start after stop missing");

  a_data_code: assert property (
    byte_done && !addr_ph_r && !eng.lost |=>
      {code_r, 3'b000} == ($past(eng.nack) ? ST_D_NACK : ST_D_ACK))
    else $error("data status wrong");

  a_arb_code: assert property (
    byte_done && eng.lost |=> flag_r && !own_r && {code_r, 3'b000} == ST_ARB)
    else $error("arbitration status wrong");

  a_hold_stall: assert property (
    st_r == C_HOLD && own_r && !wr_ctl [*3] |-> scl_oe && !eng.go)
    else $error("bus not stalled while flag set");

  c_start: cover property (start_done ##[1:300] wr_ctl && pwdata[CB_FLAG]);
  c_arb: cover property (byte_done && eng.lost);
  c_stop_start: cover property (stop_done && chain_r);
  c_rstart: cover property (start_done && own_r);

endmodule : tw_master

/* design/tw_pkg.sv */
// shared constants and types for the two-wire master transfer block
package tw_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;

  // two_wire_control bit positions
  localparam int CB_FLAG = 7;
  localparam int CB_ACK = 6;
  localparam int CB_STA = 5;
  localparam int CB_STO = 4;
  localparam int CB_WC = 3;
  localparam int CB_EN = 2;
  localparam int CB_IE = 0;

  // bus_status_register layout: code in [7:3], prescaler in [1:0]
  localparam int SB_CODE = 3;
  localparam logic [7:0] DATA_RST = 8'hFF;
  localparam logic [1:0] PRE_RST = 2'h0;

  // status codes with the prescaler bits masked
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_AW_ACK = 8'h18;
  localparam logic [7:0] ST_AW_NACK = 8'h20;
  localparam logic [7:0] ST_D_ACK = 8'h28;
  localparam logic [7:0] ST_D_NACK = 8'h30;
  localparam logic [7:0] ST_ARB = 8'h38;
  localparam logic [7:0] ST_AR_ACK = 8'h40;
  localparam logic [7:0] ST_AR_NACK = 8'h48;
  localparam logic [7:0] ST_IDLE = 8'hF8;

  // timing: one third of a serial bit (clock low, high, low phases)
  localparam int CLK_NS = 5;
  localparam int QTR_NS = 250;
  localparam logic [15:0] QTR_CYC = 16'((QTR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] LAST_BIT = 4'h8;

  typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_START = 2'b01,
    CMD_STOP = 2'b10,
    CMD_BYTE = 2'b11
  } tw_cmd_t;

endpackage : tw_pkg

/* design/tw_eng_if.sv */
// command and result signals between transfer control and bit sequencer
`timescale 1ns/1ps
interface tw_eng_if;
  tw_pkg::tw_cmd_t cmd;
  logic go;
  logic abort;
  logic [7:0] tx;
  logic done;
  logic nack;
  logic lost;
  logic scl_low;
  logic sda_low;
  modport ctl (output cmd, go, abort, tx, input done, nack, lost, scl_low, sda_low);
  modport eng (input cmd, go, abort, tx, output done, nack, lost, scl_low, sda_low);
endinterface : tw_eng_if

/* design/tw_eng.sv */
// bit sequencer: start, stop and byte shifting on the two-wire pins
`timescale 1ns/1ps
module tw_eng
  import tw_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  tw_eng_if.eng bus
);

  typedef enum logic [3:0] {
    E_IDLE = 4'h0, E_SREL = 4'h1, E_SWAIT = 4'h2, E_SDA = 4'h3,
    E_SCL = 4'h4, E_BLOW = 4'h5, E_BHIGH = 4'h6, E_BEND = 4'h7,
    E_PLOW = 4'h8, E_PHIGH = 4'h9, E_PREL = 4'hA
  } tw_est_t;

  tw_est_t st_r;
  logic scl_m_r, scl_s_r, sda_m_r, sda_s_r, sda_p_r;
  logic ebusy_r, own_r, tick;
  logic [15:0] cnt_r;
  logic [8:0] sh_r;
  logic [3:0] bit_r;

  assign tick = cnt_r == QTR_CYC - 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus-busy watch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_p_r <= 1'b1;
      ebusy_r <= 1'b0;
    end else begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_p_r <= sda_s_r;
      if (scl_s_r && sda_p_r && !sda_s_r)
        ebusy_r <= 1'b1;
      else if (scl_s_r && !sda_p_r && sda_s_r)
        ebusy_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= E_IDLE;
      cnt_r <= 16'h0000;
      sh_r <= 9'h000;
      bit_r <= 4'h0;
      own_r <= 1'b0;
      bus.scl_low <= 1'b0;
      bus.sda_low <= 1'b0;
      bus.done <= 1'b0;
      bus.nack <= 1'b0;
      bus.lost <= 1'b0;
    end else begin
      bus.done <= 1'b0;
      cnt_r <= tick ? 16'h0000 : cnt_r + 16'h0001;
      if (bus.abort) begin
        st_r <= E_IDLE;
        own_r <= 1'b0;
        bus.scl_low <= 1'b0;
        bus.sda_low <= 1'b0;
      end else begin
        unique case (st_r)
          E_IDLE: begin
            cnt_r <= 16'h0000;
            if (bus.go) begin
              bus.lost <= 1'b0;
              unique case (bus.cmd)
                CMD_START: st_r <= E_SREL;
                CMD_STOP: st_r <= E_PLOW;
                CMD_BYTE: begin
                  sh_r <= {bus.tx, 1'b1};
                  bit_r <= 4'h0;
                  st_r <= E_BLOW;
                end
                CMD_NONE: st_r <= E_IDLE;
              endcase
            end
          end
          E_SREL: begin
            bus.sda_low <= 1'b0;
            if (tick) st_r <= E_SWAIT;
          end
          E_SWAIT: begin
            bus.scl_low <= 1'b0;
            // wait for a free bus unless this master already owns it
            if (!scl_s_r || !sda_s_r || (ebusy_r && !own_r)) cnt_r <= 16'h0000;
            else if (tick) st_r <= E_SDA;
          end
          E_SDA: begin
            bus.sda_low <= 1'b1;
            if (tick) begin
              own_r <= 1'b1;
              st_r <= E_SCL;
            end
          end
          E_SCL: begin
            bus.scl_low <= 1'b1;
            if (tick) begin
              bus.done <= 1'b1;
              st_r <= E_IDLE;
            end
          end
          E_BLOW: begin
            bus.scl_low <= 1'b1;
            bus.sda_low <= ~sh_r[8];
            if (tick) st_r <= E_BHIGH;
          end
          E_BHIGH: begin
            bus.scl_low <= 1'b0;
            if (!scl_s_r) begin
              cnt_r <= 16'h0000;
            end else if (sh_r[8] && !sda_s_r && bit_r != LAST_BIT) begin
              // another master drives low where this one sent high
              own_r <= 1'b0;
              bus.sda_low <= 1'b0;
              bus.lost <= 1'b1;
              bus.done <= 1'b1;
              st_r <= E_IDLE;
            end else if (tick) begin
              bus.nack <= sda_s_r;
              st_r <= E_BEND;
            end
          end
          E_BEND: begin
            bus.scl_low <= 1'b1;
            if (tick) begin
              if (bit_r == LAST_BIT) begin
                bus.done <= 1'b1;
                st_r <= E_IDLE;
              end else begin
                sh_r <= {sh_r[7:0], 1'b1};
                bit_r <= bit_r + 4'h1;
                st_r <= E_BLOW;
              end
            end
          end
          E_PLOW: begin
            bus.scl_low <= 1'b1;
            bus.sda_low <= 1'b1;
            if (tick) st_r <= E_PHIGH;
          end
          E_PHIGH: begin
            bus.scl_low <= 1'b0;
            if (!scl_s_r) cnt_r <= 16'h0000;
            else if (tick) st_r <= E_PREL;
          end
          E_PREL: begin
            bus.sda_low <= 1'b0;
            if (tick) begin
              own_r <= 1'b0;
              bus.done <= 1'b1;
              st_r <= E_IDLE;
            end
          end
          default: st_r <= E_IDLE;
        endcase
      end
    end
  end

endmodule : tw_eng

/* verification/tw_slave_model.sv */
// behavioural two-wire slave: acknowledges, stretches the clock, contends for the data line
`timescale 1ns/1ps
module tw_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  input wire logic contend,
  input wire logic stretch,
  output logic scl_oe,
  output logic sda_oe,
  output logic [7:0] rx_byte,
  output int rx_cnt,
  output int starts,
  output int stops
);
  int bits;
  logic [7:0] sh;
  logic ack_slot;
  logic sda_ack;
  initial begin
    scl_oe = 1'b0;
    sda_ack = 1'b0;
    ack_slot = 1'b0;
    bits = 0;
    rx_byte = 8'h00;
    rx_cnt = 0;
    starts = 0;
    stops = 0;
  end
  // contend pulls data low as a rival would, so a master sending a one loses
  assign sda_oe = sda_ack | contend;
  always @(negedge sda) if (scl === 1'b1) begin
    starts++;
    bits = 0;
    ack_slot = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) stops++;
  always @(posedge scl) if (!ack_slot && bits < 8) begin
    sh = {sh[6:0], sda};
    bits++;
  end
  always @(negedge scl) begin
    if (ack_slot) begin
      sda_ack = 1'b0;
      ack_slot = 1'b0;
      bits = 0;
    end else if (bits == 8) begin
      rx_byte = sh;
      rx_cnt++;
      sda_ack = ack_en;
      ack_slot = 1'b1;
    end
    // slow slave holds the clock low after each falling edge
    if (stretch) begin
      scl_oe = 1'b1;
      #400;
      scl_oe = 1'b0;
    end
  end
endmodule : tw_slave_model

/* verification/tw_master_tb.sv */
// self-checking bench for the two-wire master transfer block
`timescale 1ns/1ps
module tw_master_tb;
  import tw_pkg::*;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, rx_byte, wa, v;
  logic [31:0] pwdata, prdata, rd;
  logic scl_o, scl_oe, sda_o, sda_oe, s_scl_oe, s_sda_oe, ack_en, contend, stretch, a;
  int rx_cnt, starts, stops, num_errors, tests_run, c0;
  logic [7:0] sent_q[$];
  wire scl = !(scl_oe | s_scl_oe);
  wire sda = !(sda_oe | s_sda_oe);
  tw_master dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  tw_slave_model peer (.scl(scl), .sda(sda), .ack_en(ack_en), .contend(contend), .stretch(stretch),
    .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .rx_byte(rx_byte), .rx_cnt(rx_cnt), .starts(starts), .stops(stops));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task conclude;
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task wait_flag(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_CTRL, 32'h0);
      n++;
    end while (rd[CB_FLAG] !== 1'b1 && n < 3000);
    if (rd[CB_FLAG] !== 1'b1) begin
      num_errors++;
      conclude();
    end
    chk(scl_oe, exp != ST_ARB);
    chk({scl_o, sda_o}, 2'b00);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd & 32'hF8, exp);
  endtask : wait_flag
  task wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STAT, 32'h0);
      n++;
    end while ((rd & 32'hF8) !== 32'hF8 && n < 3000);
    if ((rd & 32'hF8) !== 32'hF8) begin
      num_errors++;
      conclude();
    end
    chk(rd & 32'hF8, ST_IDLE);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd[CB_STO], 1'b0);
  endtask : wait_idle
  task send(input logic [7:0] b, input logic ak, input logic [7:0] exp);
    ack_en <= ak;
    apb(1'b1, ADDR_DATA, {24'h0, b});
    apb(1'b1, ADDR_CTRL, 32'h84);
    wait_flag(exp);
    if (exp != ST_ARB) begin
      sent_q.push_back(b);
      chk(rx_byte, sent_q[$]);
      chk(rx_cnt, sent_q.size());
    end
  endtask : send
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    num_errors = 0;
    tests_run = 0;
    resetn = 1'b0;
    {psel, penable, pwrite, ack_en, contend, stretch} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(45));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h00);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd, 32'hF8);
    apb(1'b0, 8'h0C, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, ADDR_DATA, 32'h5A);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd[CB_WC], 1'b1);
    apb(1'b0, ADDR_DATA, 32'h0);
    chk(rd, 32'hFF);
    apb(1'b1, ADDR_STAT, 32'h3);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd, 32'hFB);
    c0 = starts;
    apb(1'b1, ADDR_CTRL, 32'hA4);
    wait_flag(ST_START);
    chk(starts, c0 + 1);
    wa = {7'($urandom), 1'b0};
    send(wa, 1'b1, ST_AW_ACK);
    for (int i = 0; i < 4; i++) begin
      a = 1'($urandom);
      v = 8'($urandom);
      stretch <= (i == 1);
      send(v, a, a ? ST_D_ACK : ST_D_NACK);
    end
    stretch <= 1'b0;
    repeat (200) @(posedge clk);
    chk(rx_cnt, sent_q.size());
    chk(scl_oe, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'hA4);
    wait_flag(ST_RSTART);
    send(wa, 1'b0, ST_AW_NACK);
    apb(1'b1, ADDR_CTRL, 32'hA4);
    wait_flag(ST_RSTART);
    send(wa | 8'h01, 1'b1, ST_AR_ACK);
    c0 = stops;
    apb(1'b1, ADDR_CTRL, 32'h94);
    wait_idle();
    chk(stops, c0 + 1);
    apb(1'b1, ADDR_CTRL, 32'hA4);
    wait_flag(ST_START);
    send(wa, 1'b1, ST_AW_ACK);
    c0 = stops;
    apb(1'b1, ADDR_CTRL, 32'hB4);
    wait_flag(ST_START);
    chk(stops, c0 + 1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd[CB_STO], 1'b0);
    for (int k = 0; k < 2; k++) begin
      contend <= 1'b1;
      send(8'hA0, 1'b1, ST_ARB);
      if (k == 0) begin
        apb(1'b1, ADDR_CTRL, 32'h84);
        contend <= 1'b0;
        wait_idle();
        apb(1'b1, ADDR_CTRL, 32'hA4);
        wait_flag(ST_START);
      end else begin
        apb(1'b1, ADDR_CTRL, 32'hA4);
        repeat (300) @(posedge clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd[CB_FLAG], 1'b0);
        contend <= 1'b0;
        wait_flag(ST_START);
        apb(1'b1, ADDR_CTRL, 32'h94);
        wait_idle();
      end
    end
    // enable low aborts a held transfer and releases both lines
    apb(1'b1, ADDR_CTRL, 32'hA4);
    wait_flag(ST_START);
    apb(1'b1, ADDR_CTRL, 32'hC1);
    wait_idle();
    chk(scl_oe, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h41);
    conclude();
  end
endmodule : tw_master_tb
